// ===== common/gimbal_pkg.sv
// Shared constants, carriers and state codes for the gimbal command pulse output path
`default_nettype none
package gimbal_pkg;
	// Core clock and pulse train rate
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned PULSE_RATE_PPS = 3200;
	localparam int unsigned PULSE_DIV_CYCLES = CLK_HZ / PULSE_RATE_PPS;
	// Sample periods and supervisor period, in milliseconds, then in cycles
	localparam int unsigned SAMPLE_SHORT_MS = 40;
	localparam int unsigned SAMPLE_LONG_MS = 80;
	localparam int unsigned SUPERVISOR_MS = 500;
	localparam int unsigned SAMPLE_SHORT_CYCLES = SAMPLE_SHORT_MS * (CLK_HZ / 1000);
	localparam int unsigned SAMPLE_LONG_CYCLES = SAMPLE_LONG_MS * (CLK_HZ / 1000);
	localparam int unsigned SUPERVISOR_CYCLES = SUPERVISOR_MS * (CLK_HZ / 1000);
	// Output weight of one count: 85.41 arc-seconds, 0.0237 degree
	localparam int unsigned ARCSEC_PER_COUNT_X100 = 8541;
	localparam int unsigned DEG_PER_COUNT_X10000 = 237;
	// Full register: 180 degrees on input side, 388.3 degrees on output side
	localparam int unsigned INPUT_FULL_DEG = 180;
	localparam int unsigned OUTPUT_FULL_DEG_X10 = 3883;
	// Input-to-output gain in Q16, compensating the two full-register scales
	localparam logic signed [16:0] SCALE_GAIN_Q16 =
		17'((INPUT_FULL_DEG * 10 * 65536) / OUTPUT_FULL_DEG_X10);
	localparam int unsigned CNT_W = 16;
	localparam int unsigned TIMER_W = 24;
	// Release bit positions
	localparam int unsigned PITCH_BIT = 0;
	localparam int unsigned YAW_BIT = 1;
	localparam logic [1:0] RELEASE_ALL = 2'h3;
	localparam logic [1:0] RELEASE_NONE = 2'h0;
	// Pitch and yaw values travel together
	typedef struct packed {
		logic signed [CNT_W-1:0] pitch;
		logic signed [CNT_W-1:0] yaw;
	} axis_pair_type;
	// Sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_COMPUTE = 5'h02,
		ST_COPY = 5'h04,
		ST_RESTORE = 5'h08,
		ST_RATE_WAIT = 5'h10
	} seq_state_type;
endpackage
`default_nettype wire

// ===== logic/gimbal_command_pulse_output.sv
// Gimbal command pulse output path: increments, pulse release, discretes, restart recovery
`default_nettype none
// Notes on behaviour
// - Each sample, new command minus previous goes into the output counter per axis.
// - Released counter contents leave as pulses at 3200 per second.
// - One output count equals 85.41 arc-seconds, 0.0237 degree of deflection.
// - Output full register is 388.3 deg, input 180 deg; gain compensates.
// - Device raises drive enable; converter then energizes armed relays.
// - Device raises error counter enable so converter tracks increments.
// - Pending increments leave only when the pulse release bits are set.
// - Hardware restart zeros drive channels; software restart leaves them alone.
// - Hardware restart drops counter enable and drive enable; engines go to null.
// - After hardware restart, re-enable interface and reload counters before computing.
// - Then wait one more 40 or 80 ms sample before new increments.
// - Results go to temporary storage then copied; restart in copy repeats it.
// - Restart during computation redoes that section or the whole cycle.
// - Any restart re-establishes the half-second supervisor task.
module gimbal_command_pulse_output
	import gimbal_pkg::*;
#(
	parameter int unsigned PULSE_DIV = PULSE_DIV_CYCLES,
	parameter int unsigned SAMPLE_SHORT = SAMPLE_SHORT_CYCLES,
	parameter int unsigned SAMPLE_LONG = SAMPLE_LONG_CYCLES,
	parameter int unsigned SUPERVISOR = SUPERVISOR_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic control_source_switch,
	input wire logic hw_restart_pin,
	input wire logic sw_restart_pin,
	input wire logic sample_strobe,
	input wire logic signed [CNT_W-1:0] pitch_actuator_command,
	input wire logic signed [CNT_W-1:0] yaw_actuator_command,
	input wire logic long_sample_period,
	input wire logic redo_section_ok,
	input wire logic drive_enable_req,
	input wire logic counter_enable_req,
	input wire logic [1:0] release_req,
	output logic gimbal_drive_enable_ff,
	output logic error_counter_enable_ff,
	output logic [1:0] pulse_release_bits_ff,
	output logic signed [CNT_W-1:0] pitch_increment_counter,
	output logic signed [CNT_W-1:0] yaw_increment_counter,
	output logic pitch_pulse_up,
	output logic pitch_pulse_down,
	output logic yaw_pulse_up,
	output logic yaw_pulse_down,
	output logic supervisor_tick_ff,
	output logic redo_cycle_ff
);
	// Input scale to output scale, compensating the full-register difference
	function automatic logic signed [CNT_W-1:0] to_output_scale(
		input logic signed [CNT_W-1:0] cmd);
		logic signed [32:0] prod;
		prod = cmd * SCALE_GAIN_Q16;
		return prod[31:16];
	endfunction

	logic [2:0] arm_sync_ff;
	logic [2:0] hw_sync_ff;
	logic [2:0] sw_sync_ff;
	logic armed;
	logic hw_pulse;
	logic sw_pulse;
	logic restart_any;

	// Panel and restart pins are asynchronous: two stages, third only for edges
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			arm_sync_ff <= 3'h0;
			hw_sync_ff <= 3'h0;
			sw_sync_ff <= 3'h0;
		end else begin
			arm_sync_ff <= {arm_sync_ff[1:0], control_source_switch};
			hw_sync_ff <= {hw_sync_ff[1:0], hw_restart_pin};
			sw_sync_ff <= {sw_sync_ff[1:0], sw_restart_pin};
		end
	end

	assign armed = arm_sync_ff[1];
	assign hw_pulse = hw_sync_ff[1] && !hw_sync_ff[2];
	assign sw_pulse = sw_sync_ff[1] && !sw_sync_ff[2];
	assign restart_any = hw_pulse || sw_pulse;

	logic [TIMER_W-1:0] div_ff;
	logic [TIMER_W-1:0] nxt_div;
	logic [TIMER_W-1:0] super_ff;
	logic [TIMER_W-1:0] nxt_super;
	logic tick_ff;
	logic nxt_tick;
	logic nxt_super_tick;

	// Pulse rate divider and half-second supervisor; a restart re-arms the latter
	always_comb begin
		nxt_div = div_ff + 24'h000001;
		nxt_tick = 1'b0;
		if (div_ff == TIMER_W'(PULSE_DIV - 1)) begin
			nxt_div = '0;
			nxt_tick = 1'b1;
		end
		nxt_super = super_ff + 24'h000001;
		nxt_super_tick = 1'b0;
		if (restart_any) begin
			nxt_super = '0;
		end else if (super_ff == TIMER_W'(SUPERVISOR - 1)) begin
			nxt_super = '0;
			nxt_super_tick = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			div_ff <= '0;
			tick_ff <= 1'b0;
			super_ff <= '0;
			supervisor_tick_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			tick_ff <= nxt_tick;
			super_ff <= nxt_super;
			supervisor_tick_ff <= nxt_super_tick;
		end
	end

	seq_state_type state_ff;
	seq_state_type nxt_state;
	axis_pair_type tmp_cmd_ff;
	axis_pair_type nxt_tmp_cmd;
	axis_pair_type tmp_inc_ff;
	axis_pair_type nxt_tmp_inc;
	axis_pair_type perm_cmd_ff;
	axis_pair_type nxt_perm_cmd;
	logic [TIMER_W-1:0] wait_ff;
	logic [TIMER_W-1:0] nxt_wait;
	logic [TIMER_W-1:0] wait_last;
	logic hw_pending_ff;
	logic nxt_hw_pending;
	logic nxt_redo_cycle;
	logic nxt_drive;
	logic nxt_cnt_en;
	logic [1:0] nxt_release;
	logic copy_done;

	// Sequencer: capture, compute into temporaries, copy, and restart recovery
	always_comb begin
		nxt_state = state_ff;
		nxt_tmp_cmd = tmp_cmd_ff;
		nxt_tmp_inc = tmp_inc_ff;
		nxt_perm_cmd = perm_cmd_ff;
		nxt_wait = wait_ff;
		nxt_hw_pending = hw_pending_ff || hw_pulse;
		nxt_redo_cycle = 1'b0;
		copy_done = 1'b0;
		wait_last = long_sample_period ? TIMER_W'(SAMPLE_LONG - 1) : TIMER_W'(SAMPLE_SHORT - 1);
		unique case (state_ff)
			ST_IDLE: begin
				if (hw_pending_ff) begin
					nxt_state = ST_RESTORE;
				end else if (sample_strobe && !hw_pulse) begin
					nxt_tmp_cmd.pitch = to_output_scale(pitch_actuator_command);
					nxt_tmp_cmd.yaw = to_output_scale(yaw_actuator_command);
					nxt_state = ST_COMPUTE;
				end
			end
			ST_COMPUTE: begin
				if (restart_any) begin
					// Section input is still held, so a redo is safe when allowed
					if (redo_section_ok) begin
						nxt_state = ST_COMPUTE;
					end else begin
						nxt_state = ST_IDLE;
						nxt_redo_cycle = 1'b1;
					end
				end else begin
					nxt_tmp_inc.pitch = tmp_cmd_ff.pitch - perm_cmd_ff.pitch;
					nxt_tmp_inc.yaw = tmp_cmd_ff.yaw - perm_cmd_ff.yaw;
					nxt_state = ST_COPY;
				end
			end
			ST_COPY: begin
				// Commit only on a clean cycle, so a repeated copy never adds twice
				if (restart_any) begin
					nxt_state = ST_COPY;
				end else begin
					copy_done = 1'b1;
					nxt_perm_cmd = tmp_cmd_ff;
					nxt_state = ST_IDLE;
				end
			end
			ST_RESTORE: begin
				nxt_hw_pending = hw_pulse;
				nxt_wait = '0;
				nxt_state = ST_RATE_WAIT;
			end
			ST_RATE_WAIT: begin
				nxt_wait = wait_ff + 24'h000001;
				if (hw_pending_ff) begin
					nxt_state = ST_RESTORE;
				end else if (wait_ff == wait_last) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		// Discretes follow requests, held low from a hardware restart until reload
		// Next pending value, so the discretes come back on the reload edge itself
		nxt_drive = drive_enable_req && armed && !nxt_hw_pending;
		nxt_cnt_en = counter_enable_req && !nxt_hw_pending;
		nxt_release = release_req;
		if (state_ff == ST_RESTORE || state_ff == ST_RATE_WAIT) begin
			nxt_release = RELEASE_ALL;
		end
		if (hw_pulse) begin
			nxt_drive = 1'b0;
			nxt_cnt_en = 1'b0;
			nxt_release = RELEASE_NONE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state_ff <= ST_IDLE;
			tmp_cmd_ff <= '0;
			tmp_inc_ff <= '0;
			perm_cmd_ff <= '0;
			wait_ff <= '0;
			hw_pending_ff <= 1'b0;
			redo_cycle_ff <= 1'b0;
			gimbal_drive_enable_ff <= 1'b0;
			error_counter_enable_ff <= 1'b0;
			pulse_release_bits_ff <= RELEASE_NONE;
		end else begin
			state_ff <= nxt_state;
			tmp_cmd_ff <= nxt_tmp_cmd;
			tmp_inc_ff <= nxt_tmp_inc;
			perm_cmd_ff <= nxt_perm_cmd;
			wait_ff <= nxt_wait;
			hw_pending_ff <= nxt_hw_pending;
			redo_cycle_ff <= nxt_redo_cycle;
			gimbal_drive_enable_ff <= nxt_drive;
			error_counter_enable_ff <= nxt_cnt_en;
			pulse_release_bits_ff <= nxt_release;
		end
	end

	// Output counters: cleared by hardware restart, reloaded on restore
	increment_pulse_channel pitch_channel (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(hw_pulse),
		.set_en(state_ff == ST_RESTORE),
		.set_value(perm_cmd_ff.pitch),
		.add_en(copy_done),
		.add_value(tmp_inc_ff.pitch),
		.tick(tick_ff),
		.release_en(pulse_release_bits_ff[PITCH_BIT]),
		.count_ff(pitch_increment_counter),
		.pulse_up_ff(pitch_pulse_up),
		.pulse_down_ff(pitch_pulse_down)
	);

	increment_pulse_channel yaw_channel (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(hw_pulse),
		.set_en(state_ff == ST_RESTORE),
		.set_value(perm_cmd_ff.yaw),
		.add_en(copy_done),
		.add_value(tmp_inc_ff.yaw),
		.tick(tick_ff),
		.release_en(pulse_release_bits_ff[YAW_BIT]),
		.count_ff(yaw_increment_counter),
		.pulse_up_ff(yaw_pulse_up),
		.pulse_down_ff(yaw_pulse_down)
	);

	// Checks on sequencing, discretes and pulse trains
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	chk_compute_then_copy: assert property (
		state_ff == ST_COMPUTE && !restart_any |=> state_ff == ST_COPY ##1
		state_ff != ST_COPY || $past(restart_any))
		else $error("compute not followed by copy");
	chk_pulse_on_tick: assert property (
		(pitch_pulse_up || pitch_pulse_down) |-> $past(tick_ff))
		else $error("pitch pulse off the rate tick");
	chk_pulse_released: assert property (
		(yaw_pulse_up || yaw_pulse_down) |-> $past(pulse_release_bits_ff[YAW_BIT]))
		else $error("yaw pulse without release bit");
	chk_pulse_sign: assert property (
		pitch_pulse_up |-> $past(pitch_increment_counter) > 16'sh0000)
		else $error("up pulse from non-positive counter");
	chk_hw_clears_drive: assert property (
		hw_pulse |=> !gimbal_drive_enable_ff && !error_counter_enable_ff
		&& pitch_increment_counter == 16'sh0000)
		else $error("hardware restart left drive active");
	chk_sw_keeps_drive: assert property (
		sw_pulse && !hw_pulse && !hw_pending_ff && gimbal_drive_enable_ff
		&& drive_enable_req && armed |=> gimbal_drive_enable_ff)
		else $error("software restart dropped drive enable");
	chk_copy_repeats: assert property (
		state_ff == ST_COPY && restart_any |=> state_ff == ST_COPY)
		else $error("restart in copy did not repeat it");
	chk_section_choice: assert property (
		state_ff == ST_COMPUTE && restart_any && !redo_section_ok
		|=> state_ff == ST_IDLE && redo_cycle_ff)
		else $error("whole cycle redo not chosen");
	chk_restore_reload: assert property (
		state_ff == ST_RESTORE && !hw_pulse && counter_enable_req
		|=> error_counter_enable_ff && pulse_release_bits_ff == RELEASE_ALL
		&& pitch_increment_counter == $past(perm_cmd_ff.pitch))
		else $error("restore did not reload and re-enable");
	chk_wait_blocks_sample: assert property (
		state_ff == ST_RATE_WAIT |=> state_ff != ST_COMPUTE)
		else $error("new increments during rate wait");
	chk_supervisor_rearm: assert property (
		restart_any |=> super_ff == '0 && !supervisor_tick_ff)
		else $error("supervisor not re-established");

	cov_restore_path: cover property (state_ff == ST_RESTORE ##1 state_ff == ST_RATE_WAIT);
	cov_copy_repeat: cover property (state_ff == ST_COPY && restart_any);
	cov_down_pulse: cover property (yaw_pulse_down);
endmodule
`default_nettype wire

// ===== logic/increment_pulse_channel.sv
// One output counter that drains its signed contents as a released pulse train
`default_nettype none
module increment_pulse_channel
	import gimbal_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic set_en,
	input wire logic signed [CNT_W-1:0] set_value,
	input wire logic add_en,
	input wire logic signed [CNT_W-1:0] add_value,
	input wire logic tick,
	input wire logic release_en,
	output logic signed [CNT_W-1:0] count_ff,
	output logic pulse_up_ff,
	output logic pulse_down_ff
);
	logic signed [CNT_W-1:0] nxt_count;
	logic nxt_up;
	logic nxt_down;
	logic fire;

	// One pulse per rate tick while released; clear beats set beats add
	always_comb begin
		fire = tick && release_en && (count_ff != '0);
		nxt_up = fire && !count_ff[CNT_W-1];
		nxt_down = fire && count_ff[CNT_W-1];
		nxt_count = count_ff;
		if (nxt_up) begin
			nxt_count = count_ff - 16'sh0001;
		end else if (nxt_down) begin
			nxt_count = count_ff + 16'sh0001;
		end
		if (add_en) begin
			nxt_count = nxt_count + add_value;
		end
		if (set_en) begin
			nxt_count = set_value;
		end
		if (clear) begin
			nxt_count = '0;
		end
	end

	// Registered pulses and counter
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			count_ff <= '0;
			pulse_up_ff <= 1'b0;
			pulse_down_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			pulse_up_ff <= nxt_up;
			pulse_down_ff <= nxt_down;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/converter_unit_model.sv
// Behavioural model of the angle converter unit that sums pulses and drives the servos
`default_nettype none
module converter_unit_model
	import gimbal_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic control_source_switch,
	input wire logic gimbal_drive_enable,
	input wire logic error_counter_enable,
	input wire logic pitch_up,
	input wire logic pitch_down,
	input wire logic yaw_up,
	input wire logic yaw_down,
	output var axis_pair_type error_sum_ff,
	output var axis_pair_type drive_level
);
	timeunit 1ns;
	timeprecision 1ps;
	axis_pair_type nxt_error_sum;

	// Counter sums signed pulses; a dropped enable deactivates and empties it
	always_comb begin
		nxt_error_sum = error_sum_ff;
		if (!error_counter_enable) begin
			nxt_error_sum = '0;
		end else begin
			nxt_error_sum.pitch = error_sum_ff.pitch + 16'(pitch_up) - 16'(pitch_down);
			nxt_error_sum.yaw = error_sum_ff.yaw + 16'(yaw_up) - 16'(yaw_down);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			error_sum_ff <= '0;
		end else begin
			error_sum_ff <= nxt_error_sum;
		end
	end

	// Relays armed by the switch, energized only by drive enable; otherwise servos see null
	assign drive_level = (control_source_switch && gimbal_drive_enable) ? error_sum_ff : '0;
endmodule
`default_nettype wire

// ===== testbench/gimbal_command_pulse_output_tb.sv
// Self-checking bench for the gimbal command pulse output path
`default_nettype none
module gimbal_command_pulse_output_tb
	import gimbal_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PDIV = 8;
	localparam int SUP = 100;
	logic core_clk, reset_n, control_source_switch, hw_restart_pin, sw_restart_pin;
	logic sample_strobe, long_sample_period, redo_section_ok;
	logic drive_enable_req, counter_enable_req;
	logic [1:0] release_req;
	logic signed [CNT_W-1:0] pitch_actuator_command, yaw_actuator_command;
	logic gimbal_drive_enable_ff, error_counter_enable_ff, supervisor_tick_ff, redo_cycle_ff;
	logic [1:0] pulse_release_bits_ff;
	logic signed [CNT_W-1:0] pitch_increment_counter, yaw_increment_counter;
	logic pitch_pulse_up, pitch_pulse_down, yaw_pulse_up, yaw_pulse_down;
	axis_pair_type error_sum, drive_level;
	int err_total = 0;
	int n_checks = 0;
	int cycles = 0;
	int gap = 1000;
	int n;

	gimbal_command_pulse_output #(.PULSE_DIV(PDIV), .SAMPLE_SHORT(20), .SAMPLE_LONG(40),
		.SUPERVISOR(SUP)) dut (.core_clk(core_clk), .reset_n(reset_n),
		.control_source_switch(control_source_switch), .hw_restart_pin(hw_restart_pin),
		.sw_restart_pin(sw_restart_pin), .sample_strobe(sample_strobe),
		.pitch_actuator_command(pitch_actuator_command),
		.yaw_actuator_command(yaw_actuator_command), .long_sample_period(long_sample_period),
		.redo_section_ok(redo_section_ok), .drive_enable_req(drive_enable_req),
		.counter_enable_req(counter_enable_req), .release_req(release_req),
		.gimbal_drive_enable_ff(gimbal_drive_enable_ff),
		.error_counter_enable_ff(error_counter_enable_ff),
		.pulse_release_bits_ff(pulse_release_bits_ff),
		.pitch_increment_counter(pitch_increment_counter),
		.yaw_increment_counter(yaw_increment_counter), .pitch_pulse_up(pitch_pulse_up),
		.pitch_pulse_down(pitch_pulse_down), .yaw_pulse_up(yaw_pulse_up),
		.yaw_pulse_down(yaw_pulse_down), .supervisor_tick_ff(supervisor_tick_ff),
		.redo_cycle_ff(redo_cycle_ff));

	converter_unit_model partner (.core_clk(core_clk), .reset_n(reset_n),
		.control_source_switch(control_source_switch),
		.gimbal_drive_enable(gimbal_drive_enable_ff),
		.error_counter_enable(error_counter_enable_ff), .pitch_up(pitch_pulse_up),
		.pitch_down(pitch_pulse_down), .yaw_up(yaw_pulse_up), .yaw_down(yaw_pulse_down),
		.error_sum_ff(error_sum), .drive_level(drive_level));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Expected output scaling: input command times the package gain, Q16
	function automatic logic signed [15:0] scale(input logic signed [15:0] c);
		logic signed [32:0] p;
		p = c * SCALE_GAIN_Q16;
		return 16'(p >>> 16);
	endfunction

	// Hang guard; the whole sequence needs well under this many cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			end_sim();
		end
	end

	// Pulse spacing monitor on the pitch train, sampled where pulses have settled
	always @(negedge core_clk) begin
		gap++;
		if (pitch_pulse_up || pitch_pulse_down) begin
			check(32'(gap >= PDIV), 32'h1);
			gap = 0;
		end
	end

	task automatic sample(input logic signed [15:0] p, input logic signed [15:0] y);
		@(negedge core_clk);
		pitch_actuator_command = p;
		yaw_actuator_command = y;
		sample_strobe = 1'b1;
		@(negedge core_clk);
		sample_strobe = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask

	// Waits for both output counters to empty, bounded
	task automatic drain();
		n = 0;
		while ((pitch_increment_counter !== 16'h0 || yaw_increment_counter !== 16'h0)
			&& n < 5000) begin
			@(negedge core_clk);
			n++;
		end
		repeat (3) @(negedge core_clk);
		check(32'(n < 5000), 32'h1);
	endtask

	task automatic check_sums(input logic signed [15:0] p, input logic signed [15:0] y);
		check(32'(error_sum.pitch), 32'(p));
		check(32'(error_sum.yaw), 32'(y));
	endtask

	task automatic pin_pulse(ref logic pin);
		@(negedge core_clk);
		pin = 1'b1;
		repeat (3) @(negedge core_clk);
		pin = 1'b0;
	endtask

	// Restart pin raised lead cycles before a strobe: lead 1 hits compute, lead 0 hits copy
	task automatic restart_sample(ref logic pin, input int lead, input logic signed [15:0] p,
		input logic signed [15:0] y);
		@(negedge core_clk);
		pin = 1'b1;
		repeat (lead) @(negedge core_clk);
		pitch_actuator_command = p;
		yaw_actuator_command = y;
		sample_strobe = 1'b1;
		@(negedge core_clk);
		sample_strobe = 1'b0;
		@(negedge core_clk);
		check(32'(redo_cycle_ff), 32'(lead == 1 && !redo_section_ok));
		repeat (3) @(negedge core_clk);
		pin = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask

	initial begin
		{reset_n, control_source_switch, hw_restart_pin, sw_restart_pin, sample_strobe} = '0;
		{long_sample_period, drive_enable_req, counter_enable_req} = '0;
		redo_section_ok = 1'b1;
		release_req = RELEASE_NONE;
		pitch_actuator_command = '0;
		yaw_actuator_command = '0;
		repeat (5) @(negedge core_clk);
		reset_n = 1'b1;
		check(32'({gimbal_drive_enable_ff, error_counter_enable_ff, pulse_release_bits_ff}), 32'h0);
		{control_source_switch, drive_enable_req, counter_enable_req} = 3'h7;
		repeat (6) @(negedge core_clk);
		check(32'(gimbal_drive_enable_ff), 32'h1);
		check(32'(error_counter_enable_ff), 32'h1);
		// Increments wait in the counters until released
		sample(16'sh012C, -16'sh00C8);
		check(32'(pitch_increment_counter), 32'(scale(16'sh012C)));
		check(32'(yaw_increment_counter), 32'(scale(-16'sh00C8)));
		repeat (40) @(negedge core_clk);
		check(32'(pitch_increment_counter), 32'(scale(16'sh012C)));
		check_sums(16'h0, 16'h0);
		release_req = RELEASE_ALL;
		drain();
		check_sums(scale(16'sh012C), scale(-16'sh00C8));
		check(32'(drive_level), 32'(error_sum));
		// Second sample adds only the difference
		sample(-16'sh0064, 16'sh01F4);
		drain();
		check_sums(scale(-16'sh0064), scale(16'sh01F4));
		// Restart in copy repeats it once; in compute the cycle is dropped or the section redone
		restart_sample(sw_restart_pin, 0, 16'sh0190, 16'sh0190);
		drain();
		check_sums(scale(16'sh0190), scale(16'sh0190));
		redo_section_ok = 1'b0;
		restart_sample(sw_restart_pin, 1, 16'sh0064, 16'sh0064);
		drain();
		check_sums(scale(16'sh0190), scale(16'sh0190));
		redo_section_ok = 1'b1;
		restart_sample(sw_restart_pin, 1, -16'sh0064, 16'sh01F4);
		drain();
		check_sums(scale(-16'sh0064), scale(16'sh01F4));
		// Dropping the arming discrete removes drive
		control_source_switch = 1'b0;
		repeat (6) @(negedge core_clk);
		check(32'(gimbal_drive_enable_ff), 32'h0);
		check(32'(drive_level), 32'h0);
		control_source_switch = 1'b1;
		repeat (6) @(negedge core_clk);
		// Software restart restarts the supervisor but leaves the discretes alone
		pin_pulse(sw_restart_pin);
		n = 3;
		while (!supervisor_tick_ff && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		check(32'(n >= SUP - 5 && n <= SUP + 10), 32'h1);
		check(32'({gimbal_drive_enable_ff, error_counter_enable_ff}), 32'h3);
		check_sums(scale(-16'sh0064), scale(16'sh01F4));
		// Hardware restart: drop, reload, then the long rate wait ignores new samples
		long_sample_period = 1'b1;
		pin_pulse(hw_restart_pin);
		n = 0;
		while (error_counter_enable_ff && n < 10) begin
			@(negedge core_clk);
			n++;
		end
		check(32'(error_counter_enable_ff), 32'h0);
		check(32'({gimbal_drive_enable_ff, pulse_release_bits_ff}), 32'h0);
		check(32'(drive_level), 32'h0);
		n = 0;
		while (!error_counter_enable_ff && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		check(32'(gimbal_drive_enable_ff), 32'h1);
		release_req = RELEASE_NONE;
		// Past the short wait but inside the long one, so a strobe here must be ignored
		repeat (25) @(negedge core_clk);
		sample(16'sh02BC, 16'sh02BC);
		check(32'(pulse_release_bits_ff), 32'(RELEASE_ALL));
		release_req = RELEASE_ALL;
		drain();
		check_sums(scale(-16'sh0064), scale(16'sh01F4));
		release_req = RELEASE_ALL;
		repeat (50) @(negedge core_clk);
		sample(16'sh02BC, 16'sh02BC);
		drain();
		check_sums(scale(16'sh02BC), scale(16'sh02BC));
		end_sim();
	end
endmodule
`default_nettype wire
